// ### hw/uic_defs.svh
// constants for the uart interrupt / fifo control block
// assumes apb word addressing, 8-bit registers in the low byte of each word
// Summary of operation
// - line status interrupt highest, code 0110
// - data available second priority, code 0100
// - fifo mode timeout after 4 chars, code 1100
// - holding empty third, cleared by id read/holding write
// - modem status lowest, code 0000
// - char mode: holding empty set on transfer
// - fifo mode: holding empty while queue empty
// - transmit request when holding empty and enabled
// - transmitter empty when holding and shift empty
// - bit7 fifo error summary, fifo mode only
// - fifo control write-only at identification address
// - enable bit sets fifo mode, switching flushes
// - other control bits need enable bit set
// - receive flush bit self-clears, empties queue
// - transmit flush bit self-clears, empties queue
// - ready pin mode 1 when bit3 set
// - control bits 4 and 5 reserved
// - bits 7:6 pick trigger 1/4/8/14
// - id bit0 high when nothing pending
// - id bits 7:6 follow enable, 5:4 zero
// - id code frozen during identification read
`ifndef UIC_DEFS_SVH
`define UIC_DEFS_SVH
`define UIC_ADDR_ID       12'h008
`define UIC_ADDR_LSTAT    12'h014
`define UIC_ADDR_IEN      12'h004
`define UIC_ADDR_MISC     12'h020
`define UIC_ID_NONE       4'h1
`define UIC_ID_LINE       4'h6
`define UIC_ID_RXDATA     4'h4
`define UIC_ID_TIMEOUT    4'hc
`define UIC_ID_HOLD       4'h2
`define UIC_ID_MODEM      4'h0
`define UIC_TRIG_1        5'h01
`define UIC_TRIG_4        5'h04
`define UIC_TRIG_8        5'h08
`define UIC_TRIG_14       5'h0e
`define UIC_TIMEOUT_CHARS 3'h4
`define UIC_FC_EN         0
`define UIC_FC_RXFL       1
`define UIC_FC_TXFL       2
`define UIC_FC_MODE       3
`define UIC_FC_TRIG_LO    6
`define UIC_LS_HOLD       5
`define UIC_LS_TRANSMITTER_EMPTY_FLAG       6
`define UIC_LS_ERR        7
`endif

// ### hw/uic_pkg.sv
// types for the uart interrupt / fifo control block
// assumes uic_defs.svh provides the numeric constants
package uic_pkg;
	typedef struct packed {
		logic       fifo_mode;    // fifo enable bit
		logic       ready_mode;   // ready pin mode bit
		logic [1:0] trig_sel;     // receive trigger select
		logic [3:0] ien;          // enables: rx, hold, line, modem
		logic       hold_empty;   // holding empty flag
		logic       hold_irq;     // holding empty interrupt latch
		logic       err_sum;      // fifo error summary
		logic [2:0] char_cnt;     // idle character times seen
		logic       timeout;      // timeout pending
		logic [3:0] id_frozen;    // id code held during read
		logic       rx_flush;     // one-cycle receive flush pulse
		logic       tx_flush;     // one-cycle transmit flush pulse
		logic [7:0] rdata;        // apb read data
	} uic_state_s;
endpackage

// ### hw/uic_ctrl.sv
// interrupt prioritiser, transmit status and fifo control for the uart
// assumes the rest of the uart supplies error flags, queue counts, char tick
`timescale 1ns/1ps
`default_nettype none
`include "uic_defs.svh"
module uic_ctrl (
	input  wire logic        pclk,          // 100 mhz bus clock
	input  wire logic        presetn,       // async reset, active low
	input  wire logic        psel,          // apb select
	input  wire logic        penable,       // apb access phase
	input  wire logic        pwrite,        // apb direction
	input  wire logic [11:0] paddr,         // apb byte address
	input  wire logic [31:0] pwdata,        // apb write data
	output logic      [31:0] prdata,        // apb read data
	output logic             pready,        // apb ready
	output logic             pslverr,       // apb error
	input  wire logic        line_err,      // overrun/parity/framing/break pending
	input  wire logic        rx_err_in_q,   // an errored char sits in receive queue
	input  wire logic [4:0]  rx_count,      // receive queue fill
	input  wire logic        rx_data_rdy,   // char-mode data ready
	input  wire logic [4:0]  tx_count,      // transmit queue fill
	input  wire logic        shift_busy,    // transmit shift register holds a char
	input  wire logic        hold_to_shift, // pulse: holding register moved to shift
	input  wire logic        hold_write,    // pulse: host wrote holding register
	input  wire logic        rx_read,       // pulse: host read receive buffer
	input  wire logic        rx_push,       // pulse: char added to receive queue
	input  wire logic        char_tick,     // pulse: one character time elapsed
	input  wire logic        modem_delta,   // any modem change flag set
	output logic             lstat_read,    // pulse: line status read
	output logic             mstat_read,    // pulse: modem status read (misc reg)
	output logic             rx_flush,      // pulse: empty receive queue
	output logic             tx_flush,      // pulse: empty transmit queue
	output logic             fifo_mode,     // fifo mode active
	output logic             ready_mode,    // ready pin signalling mode
	output logic             tx_irq,        // transmitter interrupt request
	output logic             intr           // combined interrupt request
);
	uic_pkg::uic_state_s st_reg, st_next;
	logic       wr_en, rd_en;
	logic [3:0] id_live;
	logic [4:0] trig;
	logic       rx_avail;
	logic       q_empty;
	logic [7:0] lstat;

	// apb strobes; always zero wait states, never an error
	assign wr_en   = psel & penable & pwrite;
	assign rd_en   = psel & penable & ~pwrite;
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign prdata  = {24'h00_0000, st_reg.rdata};

	// trigger level decode
	always_comb begin
		case (st_reg.trig_sel)
			2'b00:   trig = `UIC_TRIG_1;
			2'b01:   trig = `UIC_TRIG_4;
			2'b10:   trig = `UIC_TRIG_8;
			default: trig = `UIC_TRIG_14;
		endcase
	end

	// data available follows the level: falls as soon as the queue drops below trigger
	assign rx_avail = st_reg.fifo_mode ? (rx_count >= trig) : rx_data_rdy;
	assign q_empty  = st_reg.fifo_mode ? (tx_count == 5'h00) : st_reg.hold_empty;

	// priority encode of enabled sources
	always_comb begin
		if (st_reg.ien[2] && line_err)
			id_live = `UIC_ID_LINE;
		else if (st_reg.ien[0] && rx_avail)
			id_live = `UIC_ID_RXDATA;
		else if (st_reg.ien[0] && st_reg.timeout)
			id_live = `UIC_ID_TIMEOUT;
		else if (st_reg.ien[1] && st_reg.hold_irq)
			id_live = `UIC_ID_HOLD;
		else if (st_reg.ien[3] && modem_delta)
			id_live = `UIC_ID_MODEM;
		else
			id_live = `UIC_ID_NONE;
	end

	// line status upper bits; lower error bits belong elsewhere
	assign lstat = {st_reg.fifo_mode & st_reg.err_sum,
			st_reg.hold_empty & ~shift_busy,
			st_reg.hold_empty, 5'b0_0000};

	assign intr       = (id_live != `UIC_ID_NONE);
	assign tx_irq     = st_reg.hold_empty & st_reg.ien[1];
	assign fifo_mode  = st_reg.fifo_mode;
	assign ready_mode = st_reg.ready_mode;
	assign rx_flush   = st_reg.rx_flush;
	assign tx_flush   = st_reg.tx_flush;
	assign lstat_read = rd_en && paddr == `UIC_ADDR_LSTAT;
	assign mstat_read = rd_en && paddr == `UIC_ADDR_MISC;

	// next state
	always_comb begin
		logic id_rd, id_wr, switch;
		st_next = st_reg;
		id_rd  = rd_en && paddr == `UIC_ADDR_ID;
		id_wr  = wr_en && paddr == `UIC_ADDR_ID;
		switch = id_wr && (pwdata[`UIC_FC_EN] != st_reg.fifo_mode);
		st_next.rx_flush = 1'b0;
		st_next.tx_flush = 1'b0;
		st_next.rdata    = 8'h00;
		// fifo control write; other bits only take with enable set
		if (id_wr) begin
			st_next.fifo_mode = pwdata[`UIC_FC_EN];
			if (pwdata[`UIC_FC_EN]) begin
				st_next.ready_mode = pwdata[`UIC_FC_MODE];
				st_next.trig_sel   = pwdata[`UIC_FC_TRIG_LO +: 2];
				st_next.rx_flush   = pwdata[`UIC_FC_RXFL];
				st_next.tx_flush   = pwdata[`UIC_FC_TXFL];
			end
			if (switch || !pwdata[`UIC_FC_EN]) begin
				st_next.rx_flush = 1'b1;
				st_next.tx_flush = 1'b1;
			end
			// bits 5:4 reserved, dropped
		end
		if (wr_en && paddr == `UIC_ADDR_IEN)
			st_next.ien = pwdata[3:0];
		// holding empty: char mode moves with transfer/load, fifo mode tracks queue
		if (st_next.fifo_mode)
			st_next.hold_empty = (tx_count == 5'h00 || st_next.tx_flush) && !hold_write;
		else if (hold_write)
			st_next.hold_empty = 1'b0;
		else if (hold_to_shift || switch)
			st_next.hold_empty = 1'b1;
		// holding interrupt: cleared by id read while reported or a write; set wins
		if ((id_rd && st_reg.id_frozen == `UIC_ID_HOLD) || hold_write)
			st_next.hold_irq = 1'b0;
		if (st_next.hold_empty && !st_reg.hold_empty)
			st_next.hold_irq = 1'b1;
		// error summary: line status read clears only if none remain
		if (lstat_read && !rx_err_in_q)
			st_next.err_sum = 1'b0;
		if (rx_err_in_q && st_reg.fifo_mode)
			st_next.err_sum = 1'b1;
		if (!st_reg.fifo_mode)
			st_next.err_sum = 1'b0;
		// timeout counter: any queue activity restarts it
		if (!st_reg.fifo_mode || rx_count == 5'h00 || rx_push || rx_read) begin
			st_next.char_cnt = 3'h0;
			st_next.timeout  = 1'b0;
		end else if (char_tick && st_reg.char_cnt != `UIC_TIMEOUT_CHARS) begin
			st_next.char_cnt = st_reg.char_cnt + 3'h1;
		end
		if (st_next.char_cnt == `UIC_TIMEOUT_CHARS)
			st_next.timeout = 1'b1;
		// id code frozen while a read is in progress
		if (!(psel && !pwrite && paddr == `UIC_ADDR_ID))
			st_next.id_frozen = id_live;
		// read mux: loaded at the setup edge, held through the access cycle
		if (psel && !penable && !pwrite) begin
			case (paddr)
				`UIC_ADDR_ID:
					st_next.rdata = {{2{st_reg.fifo_mode}}, 2'b00, st_reg.id_frozen};
				`UIC_ADDR_LSTAT: st_next.rdata = lstat;
				`UIC_ADDR_IEN:   st_next.rdata = {4'h0, st_reg.ien};
				`UIC_ADDR_MISC:  st_next.rdata = {4'h0, st_reg.ready_mode, st_reg.fifo_mode, st_reg.trig_sel};
				default:         st_next.rdata = 8'h00;
			endcase
		end else if (rd_en) begin
			st_next.rdata = st_reg.rdata;
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg            <= '0;
			st_reg.hold_empty <= 1'b1;
			st_reg.id_frozen  <= `UIC_ID_NONE;
		end else begin
			st_reg <= st_next;
		end
	end

	// read data comes from the register loaded at the setup edge, so a zero-wait access
	// edge already sees it; reads clear their sources only at the access edge
	sequence s_id_setup;
		psel && !penable && !pwrite && paddr == `UIC_ADDR_ID;
	endsequence
	sequence s_id_access;
		rd_en && paddr == `UIC_ADDR_ID;
	endsequence
	sequence s_ctrl_write;
		wr_en && paddr == `UIC_ADDR_ID && pwdata[`UIC_FC_EN];
	endsequence

	property p_id_none;
		@(posedge pclk) disable iff (!presetn)
		(id_live == `UIC_ID_NONE) |-> !intr;
	endproperty
	a_id_none: assert property (p_id_none) else $error("intr with no source");

	property p_line_top;
		@(posedge pclk) disable iff (!presetn)
		(line_err && st_reg.ien[2]) |-> id_live == `UIC_ID_LINE;
	endproperty
	a_line_top: assert property (p_line_top) else $error("line status not top");

	property p_txirq;
		@(posedge pclk) disable iff (!presetn)
		(hold_to_shift && !hold_write && !wr_en && !st_reg.fifo_mode && st_reg.ien[1]) |=> tx_irq;
	endproperty
	a_txirq: assert property (p_txirq) else $error("tx request wrong");

	property p_flush_pulse;
		@(posedge pclk) disable iff (!presetn)
		rx_flush |=> !rx_flush || $past(wr_en);
	endproperty
	a_flush_pulse: assert property (p_flush_pulse) else $error("rx flush stuck");

	property p_txflush;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && paddr == `UIC_ADDR_ID && pwdata[0] && pwdata[2]) |=> tx_flush;
	endproperty
	a_txflush: assert property (p_txflush) else $error("tx flush missed");

	property p_gate;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && paddr == `UIC_ADDR_ID && !pwdata[0]) |=> $stable(ready_mode) && !fifo_mode;
	endproperty
	a_gate: assert property (p_gate) else $error("control bits taken without enable");

	property p_transmitter_empty_flag;
		@(posedge pclk) disable iff (!presetn)
		shift_busy |-> !lstat[`UIC_LS_TRANSMITTER_EMPTY_FLAG];
	endproperty
	a_transmitter_empty_flag: assert property (p_transmitter_empty_flag) else $error("transmitter empty while busy");

	property p_err_char;
		@(posedge pclk) disable iff (!presetn)
		!fifo_mode |-> !lstat[`UIC_LS_ERR];
	endproperty
	a_err_char: assert property (p_err_char) else $error("error summary in char mode");

	property p_freeze;
		@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !pwrite && paddr == `UIC_ADDR_ID) |=> $stable(st_reg.id_frozen);
	endproperty
	a_freeze: assert property (p_freeze) else $error("id changed during read");

	property p_hold_fifo_set;
		@(posedge pclk) disable iff (!presetn)
		(st_reg.fifo_mode && q_empty && !wr_en && !hold_write) |=> lstat[`UIC_LS_HOLD];
	endproperty
	a_hold_fifo_set: assert property (p_hold_fifo_set) else $error("holding empty not set on empty queue");

	property p_hold_fifo_clr;
		@(posedge pclk) disable iff (!presetn)
		(st_reg.fifo_mode && !q_empty && !wr_en) |=> !lstat[`UIC_LS_HOLD];
	endproperty
	a_hold_fifo_clr: assert property (p_hold_fifo_clr) else $error("holding empty with bytes queued");

	property p_hold_load;
		@(posedge pclk) disable iff (!presetn)
		(!st_reg.fifo_mode && hold_write && !wr_en) |=> !lstat[`UIC_LS_HOLD];
	endproperty
	a_hold_load: assert property (p_hold_load) else $error("holding empty after load");

	property p_hold_move;
		@(posedge pclk) disable iff (!presetn)
		(!st_reg.fifo_mode && hold_to_shift && !hold_write && !wr_en) |=> lstat[`UIC_LS_HOLD];
	endproperty
	a_hold_move: assert property (p_hold_move) else $error("holding empty not set on transfer");

	property p_hold_irq_clr;
		@(posedge pclk) disable iff (!presetn)
		s_id_access ##0 (st_reg.id_frozen == `UIC_ID_HOLD && st_reg.hold_empty) |=> !st_reg.hold_irq;
	endproperty
	a_hold_irq_clr: assert property (p_hold_irq_clr) else $error("holding interrupt survives id read");

	property p_rx_second;
		@(posedge pclk) disable iff (!presetn)
		(st_reg.ien[0] && rx_avail && !(st_reg.ien[2] && line_err)) |-> id_live == `UIC_ID_RXDATA;
	endproperty
	a_rx_second: assert property (p_rx_second) else $error("data available not reported");

	property p_timeout_code;
		@(posedge pclk) disable iff (!presetn)
		(st_reg.ien[0] && st_reg.timeout && !rx_avail && !(st_reg.ien[2] && line_err)) |-> id_live == `UIC_ID_TIMEOUT;
	endproperty
	a_timeout_code: assert property (p_timeout_code) else $error("timeout not reported");

	property p_timeout_mode;
		@(posedge pclk) disable iff (!presetn)
		!st_reg.fifo_mode |=> !st_reg.timeout;
	endproperty
	a_timeout_mode: assert property (p_timeout_mode) else $error("timeout in character mode");

	property p_modem_low;
		@(posedge pclk) disable iff (!presetn)
		(st_reg.ien[3] && modem_delta) |-> intr;
	endproperty
	a_modem_low: assert property (p_modem_low) else $error("modem change not requested");

	property p_id_bits;
		@(posedge pclk) disable iff (!presetn)
		s_id_setup |=> prdata[7] == $past(fifo_mode) && prdata[6] == $past(fifo_mode) && prdata[5:4] == 2'b00;
	endproperty
	a_id_bits: assert property (p_id_bits) else $error("id upper bits wrong");

	property p_id_code;
		@(posedge pclk) disable iff (!presetn)
		s_id_setup |=> prdata[3:0] == $past(st_reg.id_frozen);
	endproperty
	a_id_code: assert property (p_id_code) else $error("id code not the frozen one");

	property p_rx_flush_cmd;
		@(posedge pclk) disable iff (!presetn)
		s_ctrl_write ##0 pwdata[`UIC_FC_RXFL] |=> rx_flush;
	endproperty
	a_rx_flush_cmd: assert property (p_rx_flush_cmd) else $error("rx flush missed");

	property p_mode_set;
		@(posedge pclk) disable iff (!presetn)
		s_ctrl_write |=> ready_mode == $past(pwdata[`UIC_FC_MODE]);
	endproperty
	a_mode_set: assert property (p_mode_set) else $error("ready mode not taken");

	property p_trig_set;
		@(posedge pclk) disable iff (!presetn)
		s_ctrl_write |=> st_reg.trig_sel == $past(pwdata[7:6]);
	endproperty
	a_trig_set: assert property (p_trig_set) else $error("trigger select not taken");

	property p_switch_flush;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && paddr == `UIC_ADDR_ID && pwdata[`UIC_FC_EN] != fifo_mode) |=> rx_flush && tx_flush;
	endproperty
	a_switch_flush: assert property (p_switch_flush) else $error("mode switch without flush");

	property p_enable;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && paddr == `UIC_ADDR_ID) |=> fifo_mode == $past(pwdata[`UIC_FC_EN]);
	endproperty
	a_enable: assert property (p_enable) else $error("fifo mode not taken");

	property p_err_set;
		@(posedge pclk) disable iff (!presetn)
		(fifo_mode && rx_err_in_q && !wr_en) |=> lstat[`UIC_LS_ERR];
	endproperty
	a_err_set: assert property (p_err_set) else $error("error summary not set");
endmodule // uic_ctrl
`default_nettype wire

// ### testbench/uic_apb_host.sv
// apb host model: issues one register transfer at a time
// assumes read data stands through the access phase and is taken at the ready edge
`timescale 1ns/1ps
`default_nettype none
module uic_apb_host (
	input  wire logic        pclk,    // bus clock
	input  wire logic        pready,  // slave ready
	input  wire logic [31:0] prdata,  // slave read data
	output logic             psel,    // select
	output logic             penable, // access phase
	output logic             pwrite,  // direction
	output logic [11:0]      paddr,   // byte address
	output logic [31:0]      pwdata   // write data
);
	// bus idle from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
	end
	// request held until pready is seen; the wait is bounded so a dead slave cannot hang
	// line status is never written reserved control bits are zero one control write clears the enable bit
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic late);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// request stands until the edge that shows pready high; data is taken at that edge
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		q = prdata;
		late = (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		// settle time before the caller looks at outputs
		#1;
	endtask
endmodule // uic_apb_host
`default_nettype wire

// ### testbench/test_uart_interrupt_fifo_control.sv
// self-checking bench for the uart interrupt and fifo control block
// assumes uic_apb_host as bus master; status inputs are driven here
`timescale 1ns/1ps
`default_nettype none
`include "uic_defs.svh"
module test_uart_interrupt_fifo_control;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, late;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [4:0]  lvl, pls, rx_count, tx_count;
	logic        line_err, rx_err_in_q, rx_data_rdy, shift_busy, modem_delta;
	logic        hold_to_shift, hold_write, rx_read, rx_push, char_tick;
	logic        lstat_read, mstat_read, rx_flush, tx_flush, fifo_mode, ready_mode, tx_irq, intr;
	int          failures = 0, n_compared = 0, n_rxfl = 0, n_txfl = 0, erx = 0, etx = 0;
	int          n_lsr = 0, n_msr = 0;
	typedef struct packed { logic [4:0] l; logic [7:0] id; logic irq; } uic_row_s;
	uic_row_s    rows [4] = '{'{5'h15, 8'h06, 1'b1}, '{5'h05, 8'h04, 1'b1},
		'{5'h01, 8'h00, 1'b1}, '{5'h00, 8'h01, 1'b0}};
	logic [4:0]  trig [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};
	assign {line_err, rx_err_in_q, rx_data_rdy, shift_busy, modem_delta} = lvl;
	assign {hold_to_shift, hold_write, rx_read, rx_push, char_tick} = pls;
	uic_ctrl uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .line_err, .rx_err_in_q, .rx_count, .rx_data_rdy, .tx_count, .shift_busy,
		.hold_to_shift, .hold_write, .rx_read, .rx_push, .char_tick, .modem_delta, .lstat_read,
		.mstat_read, .rx_flush, .tx_flush, .fifo_mode, .ready_mode, .tx_irq, .intr);
	uic_apb_host host (.pclk, .pready, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata);
	always #5 pclk = ~pclk;
	// flush pulses are counted, so a stuck or doubled pulse shows up
	always @(posedge pclk) begin
		n_rxfl += (rx_flush === 1'b1);
		n_txfl += (tx_flush === 1'b1);
		n_lsr += (lstat_read === 1'b1);
		n_msr += (mstat_read === 1'b1);
	end
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		chk8({7'h00, got}, {7'h00, exp});
	endtask
	// one transfer; a read is compared under a mask
	task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d,
		input logic [7:0] exp, input logic [7:0] m);
		host.xfer(wr, a, {24'h00_0000, d}, rd, late);
		if (late) begin
			failures++;
			final_report();
		end
		if (!wr) chk8(rd[7:0] & m, exp);
	endtask
	// fifo control write, then flush pulse counts against expectation
	task automatic fw(input logic [7:0] d, input int drx, input int dtx);
		bus(1'b1, `UIC_ADDR_ID, d, 8'h00, 8'h00);
		repeat (2) @(posedge pclk);
		#1;
		erx += drx;
		etx += dtx;
		chk8(n_rxfl[7:0], erx[7:0]);
		chk8(n_txfl[7:0], etx[7:0]);
	endtask
	task automatic setl(input logic [4:0] l, input logic [4:0] rc, input logic [4:0] tc);
		@(posedge pclk);
		lvl <= l;
		rx_count <= rc;
		tx_count <= tc;
	endtask
	// one-cycle strobe; settle time left before anyone looks at outputs
	task automatic pulse(input int k);
		@(posedge pclk);
		pls[k] <= 1'b1;
		@(posedge pclk);
		pls[k] <= 1'b0;
		#1;
	endtask
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		lvl = 5'h00;
		pls = 5'h00;
		rx_count = 5'h00;
		tx_count = 5'h00;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		chk1(fifo_mode, 1'b0);
		chk1(ready_mode, 1'b0);
		bus(1'b0, `UIC_ADDR_MISC, 8'h00, 8'h00, 8'hff);
		bus(1'b0, `UIC_ADDR_ID, 8'h00, 8'h01, 8'hff);
		bus(1'b0, `UIC_ADDR_LSTAT, 8'h00, 8'h60, 8'he0);
		bus(1'b0, 12'h100, 8'h00, 8'h00, 8'hff);
		chk1(pslverr, 1'b0);
		bus(1'b1, `UIC_ADDR_IEN, 8'h02, 8'h00, 8'h00);
		chk1(tx_irq, 1'b1);
		pulse(3);
		chk1(tx_irq, 1'b0);
		setl(5'h02, 5'h00, 5'h00);
		pulse(4);
		bus(1'b0, `UIC_ADDR_LSTAT, 8'h00, 8'h20, 8'he0);
		bus(1'b0, `UIC_ADDR_ID, 8'h00, 8'h02, 8'hff);
		bus(1'b0, `UIC_ADDR_ID, 8'h00, 8'h01, 8'hff);
		pulse(3);
		setl(5'h08, 5'h00, 5'h00);
		bus(1'b0, `UIC_ADDR_LSTAT, 8'h00, 8'h00, 8'h80);
		// priority rows in character mode, all sources enabled
		bus(1'b1, `UIC_ADDR_IEN, 8'h0f, 8'h00, 8'h00);
		foreach (rows[i]) begin
			setl(rows[i].l, 5'h00, 5'h00);
			bus(1'b0, `UIC_ADDR_ID, 8'h00, rows[i].id, 8'hff);
			chk1(intr, rows[i].irq);
		end
		fw(8'h0f, 1, 1);
		chk1(fifo_mode, 1'b1);
		chk1(ready_mode, 1'b1);
		fw(8'h01, 0, 0);
		chk1(ready_mode, 1'b0);
		fw(8'h03, 1, 0);
		fw(8'h05, 0, 1);
		fw(8'h41, 0, 0);
		fw(8'hc0, 1, 1);
		chk1(fifo_mode, 1'b0);
		bus(1'b0, `UIC_ADDR_MISC, 8'h00, 8'h01, 8'h07);
		// each trigger level: one below stays quiet, at level reports data
		bus(1'b1, `UIC_ADDR_IEN, 8'h01, 8'h00, 8'h00);
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, `UIC_ADDR_ID, {i[1:0], 6'h01}, 8'h00, 8'h00);
			setl(5'h00, trig[i] - 5'h01, 5'h00);
			bus(1'b0, `UIC_ADDR_ID, 8'h00, 8'hc1, 8'hff);
			setl(5'h00, trig[i], 5'h00);
			bus(1'b0, `UIC_ADDR_ID, 8'h00, 8'hc4, 8'hff);
		end
		// timeout needs the fourth idle character time, a read clears it
		setl(5'h00, 5'h01, 5'h00);
		repeat (3) pulse(0);
		bus(1'b0, `UIC_ADDR_ID, 8'h00, 8'hc1, 8'hff);
		pulse(0);
		bus(1'b0, `UIC_ADDR_ID, 8'h00, 8'hcc, 8'hff);
		pulse(2);
		bus(1'b0, `UIC_ADDR_ID, 8'h00, 8'hc1, 8'hff);
		setl(5'h00, 5'h00, 5'h01);
		bus(1'b0, `UIC_ADDR_LSTAT, 8'h00, 8'h00, 8'he0);
		setl(5'h02, 5'h00, 5'h00);
		bus(1'b0, `UIC_ADDR_LSTAT, 8'h00, 8'h20, 8'he0);
		setl(5'h08, 5'h00, 5'h00);
		bus(1'b0, `UIC_ADDR_LSTAT, 8'h00, 8'h80, 8'h80);
		setl(5'h00, 5'h00, 5'h00);
		bus(1'b0, `UIC_ADDR_LSTAT, 8'h00, 8'h80, 8'h80);
		bus(1'b0, `UIC_ADDR_LSTAT, 8'h00, 8'h60, 8'he0);
		// every status read must hand one read pulse to the rest of the uart
		chk8(n_lsr[7:0], 8'h08);
		chk8(n_msr[7:0], 8'h02);
		// reset in mid-run drops fifo mode and the trigger taken since
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		chk1(fifo_mode, 1'b0);
		bus(1'b0, `UIC_ADDR_MISC, 8'h00, 8'h00, 8'hff);
		bus(1'b0, `UIC_ADDR_ID, 8'h00, 8'h01, 8'hff);
		final_report();
	end
endmodule // test_uart_interrupt_fifo_control
`default_nettype wire
